// ==== cod_mc_timer.v ====
// machine cycle timer: counts execution time in two-clock machine cycles
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.vh"

module cod_mc_timer #(
	parameter CLKS_PER_MC = `COD_CLKS_PER_MC
) (
	// clock and reset
	input wire clk_i,
	input wire srst_i,
	// control
	input wire start_i,
	input wire [`COD_MC_CNT_W-1:0] mc_count_i,
	// status
	output reg busy_o,
	output reg mc_tick_o,
	output reg done_o
);

	reg [`COD_MC_CNT_W-1:0] mc_left;
	reg [1:0] phase;

	always @(posedge clk_i) begin
		if (srst_i) begin
			busy_o <= 1'b0;
			mc_tick_o <= 1'b0;
			done_o <= 1'b0;
			mc_left <= {`COD_MC_CNT_W{1'b0}};
			phase <= 2'h0;
		end else begin
			mc_tick_o <= 1'b0;
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				busy_o <= 1'b1;
				mc_left <= mc_count_i;
				phase <= 2'h0;
			end else if (busy_o) begin
				// each machine cycle spans two clocks [RULE1]
				if (phase == CLKS_PER_MC[1:0] - 2'h1) begin
					phase <= 2'h0;
					mc_tick_o <= 1'b1;
					mc_left <= mc_left - 1'b1;
					if (mc_left == {{(`COD_MC_CNT_W-1){1'b0}}, 1'b1}) begin
						busy_o <= 1'b0;
						done_o <= 1'b1;
					end
				end else begin
					phase <= phase + 2'h1;
				end
			end
		end
	end

endmodule // cod_mc_timer

`default_nettype wire

// ==== cod_op_decoder.v ====
// opcode decoder for arithmetic, logical and data transfer instructions
// Summary of operation
// RULE1: a machine cycle is two clocks; all timing counts in machine cycles
// RULE2: each opcode has length one, two or three bytes
// RULE3: execution is 1, 2 or 4 cycles; multiply A4 and divide 84 take four
// RULE4: add decodes 28-2F, 25, 26-27, 24 in one cycle
// RULE5: add with carry decodes 38-3F, 35, 36-37, 34
// RULE6: subtract with borrow decodes 98-9F, 95, 96-97, 94
// RULE7: increment decodes 04, 08-0F, 05, 06-07 in one cycle
// RULE8: decrement decodes 14, 18-1F, 15, 16-17 in one cycle
// RULE9: A3 increments data pointer, one byte, two cycles
// RULE10: AND decodes 58-5F, 55, 56-57, 54, 52, and 53 three bytes two cycles
// RULE11: OR decodes 48-4F, 45, 46-47, 44, 42, and 43 three bytes two cycles
// RULE12: XOR decodes 68-6F, 65, 66-67, 64, 62, and 63 three bytes two cycles
// RULE13: rotations 23, 03, 33, 13 are one byte one cycle
// RULE14: loads into A decode E8-EF, E5, E6-E7, 74 in one cycle
// RULE15: A8-AF loads bank register from direct, two bytes two cycles
// RULE16: 85 copies direct to direct, three bytes two cycles
// RULE17: 90 loads data pointer from immediate, three bytes two cycles
// RULE18: 93 and 83 read program memory, one byte two cycles
// RULE19: E0, F0, E2-E3, F2-F3 external data, one byte two cycles
// RULE20: C0 push and D0 pop, two bytes two cycles
// RULE21: exchange decodes C8-CF, C5, C6-C7 in one cycle
// RULE22: D6-D7 swap low nibbles with indirect memory, one byte one cycle
// RULE23: register number is opcode bits 2:0 for bank ranges
// RULE24: decode results presented in the opcode's decode cycle
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.vh"

module cod_op_decoder #(
	parameter CLKS_PER_MC = `COD_CLKS_PER_MC
) (
	// clock and reset
	input wire CLK_I,
	input wire SRST_I,
	// opcode from fetch
	input wire OPCODE_VALID_I,
	input wire [7:0] OPCODE_I,
	// decode results
	output reg DEC_VALID_O,
	output reg DEC_ILLEGAL_O,
	output reg [`COD_OP_W-1:0] OP_CLASS_O,
	output reg [`COD_SEL_W-1:0] SRC_SEL_O,
	output reg [`COD_SEL_W-1:0] DST_SEL_O,
	output reg [2:0] REG_NUM_O,
	output reg IND_SEL_O,
	output reg XDAT_WRITE_O,
	output reg [1:0] LEN_O,
	output reg [`COD_MC_CNT_W-1:0] MC_COUNT_O,
	// execution timing
	output reg EXEC_BUSY_O,
	output reg MC_TICK_O,
	output reg EXEC_DONE_O
);

	reg [`COD_OP_W-1:0] next_op;
	reg [`COD_SEL_W-1:0] next_src;
	reg [`COD_SEL_W-1:0] next_dst;
	reg [1:0] next_len;
	reg [`COD_MC_CNT_W-1:0] next_mc;
	reg next_illegal;
	reg [3:0] mode;
	wire tm_busy;
	wire tm_tick;
	wire tm_done;

	////////////////////////////////////////////////////////////////////////
	// operand form from low nibble: 4 imm, 5 dir, 6-7 ind, 8-F bank
	function [`COD_SEL_W-1:0] low_form;
		input [3:0] lo;
		begin
			if (lo[3])
				low_form = `COD_SEL_BANK;
			else if (lo[2:1] == 2'h3)
				low_form = `COD_SEL_IND;
			else if (lo[2:0] == 3'h5)
				low_form = `COD_SEL_DIR;
			else if (lo[2:0] == 3'h4)
				low_form = `COD_SEL_IMM;
			else
				low_form = `COD_SEL_NONE;
		end
	endfunction

	// length of the common accumulator forms: dir and imm carry one operand
	function [1:0] form_len;
		input [`COD_SEL_W-1:0] form;
		begin
			if (form == `COD_SEL_DIR || form == `COD_SEL_IMM)
				form_len = `COD_LEN_2; // [RULE2]
			else
				form_len = `COD_LEN_1; // [RULE2]
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// combinational decode
	always @* begin
		next_op = `COD_OP_ILLEGAL;
		next_src = `COD_SEL_NONE;
		next_dst = `COD_SEL_NONE;
		next_len = `COD_LEN_1;
		next_mc = `COD_MC_1;
		next_illegal = 1'b0;
		mode = OPCODE_I[3:0];
		// accumulator operand groups sharing the 4/5/6-7/8-F layout
		if (mode >= 4'h4 && (OPCODE_I[7:4] == 4'h2 || OPCODE_I[7:4] == 4'h3 ||
			OPCODE_I[7:4] == 4'h9 || OPCODE_I[7:4] == 4'h4 ||
			OPCODE_I[7:4] == 4'h5 || OPCODE_I[7:4] == 4'h6)) begin
			next_src = low_form(mode);
			next_dst = `COD_SEL_ACC;
			next_len = form_len(next_src);
			case (OPCODE_I[7:4])
				4'h2: next_op = `COD_OP_ADD; // [RULE4]
				4'h3: next_op = `COD_OP_ADDC; // [RULE5]
				4'h9: next_op = `COD_OP_SUBB; // [RULE6]
				4'h4: next_op = `COD_OP_OR; // [RULE11]
				4'h5: next_op = `COD_OP_AND; // [RULE10]
				default: next_op = `COD_OP_XOR; // [RULE12]
			endcase
		end else if (mode >= 4'h5 && (OPCODE_I[7:4] == 4'h0 || OPCODE_I[7:4] == 4'h1)) begin
			// inc/dec of dir, ind, bank [RULE7] [RULE8]
			next_op = OPCODE_I[4] ? `COD_OP_DEC : `COD_OP_INC;
			next_src = low_form(mode);
			next_dst = next_src;
			next_len = form_len(next_src);
		end else if (mode >= 4'h5 && OPCODE_I[7:4] == 4'hE) begin
			next_op = `COD_OP_MOV; // [RULE14]
			next_src = low_form(mode);
			next_dst = `COD_SEL_ACC;
			next_len = form_len(next_src);
		end else if (mode >= 4'h5 && OPCODE_I[7:4] == 4'hC) begin
			next_op = `COD_OP_XCH; // [RULE21]
			next_src = low_form(mode);
			next_dst = `COD_SEL_ACC;
			next_len = form_len(next_src);
		end else if (OPCODE_I[7:3] == 5'h15) begin
			next_op = `COD_OP_MOV; // [RULE15]
			next_src = `COD_SEL_DIR;
			next_dst = `COD_SEL_BANK;
			next_len = `COD_LEN_2;
			next_mc = `COD_MC_2;
		end else if (OPCODE_I == 8'h52 || OPCODE_I == 8'h42 || OPCODE_I == 8'h62 ||
			OPCODE_I == 8'h53 || OPCODE_I == 8'h43 || OPCODE_I == 8'h63) begin
			// logic into direct byte [RULE10] [RULE11] [RULE12]
			next_op = (OPCODE_I[7:4] == 4'h5) ? `COD_OP_AND :
				(OPCODE_I[7:4] == 4'h4) ? `COD_OP_OR : `COD_OP_XOR;
			next_dst = `COD_SEL_DIR;
			next_src = OPCODE_I[0] ? `COD_SEL_IMM : `COD_SEL_ACC;
			next_len = OPCODE_I[0] ? `COD_LEN_3 : `COD_LEN_2;
			next_mc = OPCODE_I[0] ? `COD_MC_2 : `COD_MC_1;
		end else if (OPCODE_I == 8'hE2 || OPCODE_I == 8'hE3 || OPCODE_I == 8'hE0 ||
			OPCODE_I == 8'hF2 || OPCODE_I == 8'hF3 || OPCODE_I == 8'hF0) begin
			next_op = `COD_OP_MOVX; // [RULE19]
			next_mc = `COD_MC_2;
			if (OPCODE_I[4]) begin
				next_src = `COD_SEL_ACC;
				next_dst = OPCODE_I[1] ? `COD_SEL_XDAT_IND : `COD_SEL_XDAT_DP;
			end else begin
				next_dst = `COD_SEL_ACC;
				next_src = OPCODE_I[1] ? `COD_SEL_XDAT_IND : `COD_SEL_XDAT_DP;
			end
		end else if (OPCODE_I == 8'hD6 || OPCODE_I == 8'hD7) begin
			next_op = `COD_OP_XCHD; // [RULE22]
			next_src = `COD_SEL_IND;
			next_dst = `COD_SEL_ACC;
		end else begin
			case (OPCODE_I)
				8'h04, 8'h14: begin
					next_op = OPCODE_I[4] ? `COD_OP_DEC : `COD_OP_INC; // [RULE7] [RULE8]
					next_src = `COD_SEL_ACC;
					next_dst = `COD_SEL_ACC;
				end
				8'hA3: begin
					next_op = `COD_OP_INC_DP; // [RULE9]
					next_src = `COD_SEL_DP;
					next_dst = `COD_SEL_DP;
					next_mc = `COD_MC_2;
				end
				8'hA4, 8'h84: begin
					next_op = OPCODE_I[5] ? `COD_OP_MUL : `COD_OP_DIV;
					next_src = `COD_SEL_B;
					next_dst = `COD_SEL_ACC;
					next_mc = `COD_MC_4; // [RULE3]
				end
				8'hD4: begin
					next_op = `COD_OP_DA;
					next_dst = `COD_SEL_ACC;
				end
				8'hE4, 8'hF4, 8'hC4: begin
					next_op = (OPCODE_I == 8'hE4) ? `COD_OP_CLR :
						(OPCODE_I == 8'hF4) ? `COD_OP_CPL : `COD_OP_SWAP;
					next_dst = `COD_SEL_ACC;
				end
				8'h23, 8'h33, 8'h03, 8'h13: begin
					next_op = (OPCODE_I == 8'h23) ? `COD_OP_RL : // [RULE13]
						(OPCODE_I == 8'h33) ? `COD_OP_RLC :
						(OPCODE_I == 8'h03) ? `COD_OP_RR : `COD_OP_RRC;
					next_src = `COD_SEL_ACC;
					next_dst = `COD_SEL_ACC;
				end
				8'h74: begin
					next_op = `COD_OP_MOV; // [RULE14]
					next_src = `COD_SEL_IMM;
					next_dst = `COD_SEL_ACC;
					next_len = `COD_LEN_2;
				end
				8'h85: begin
					next_op = `COD_OP_MOV; // [RULE16]
					next_src = `COD_SEL_DIR;
					next_dst = `COD_SEL_DIR;
					next_len = `COD_LEN_3;
					next_mc = `COD_MC_2;
				end
				8'h90: begin
					next_op = `COD_OP_MOV_DP; // [RULE17]
					next_src = `COD_SEL_IMM16;
					next_dst = `COD_SEL_DP;
					next_len = `COD_LEN_3;
					next_mc = `COD_MC_2;
				end
				8'h93, 8'h83: begin
					next_op = `COD_OP_MOVC; // [RULE18]
					next_src = OPCODE_I[4] ? `COD_SEL_CODE_DP : `COD_SEL_CODE_PC;
					next_dst = `COD_SEL_ACC;
					next_mc = `COD_MC_2;
				end
				8'hC0, 8'hD0: begin
					next_op = OPCODE_I[4] ? `COD_OP_POP : `COD_OP_PUSH; // [RULE20]
					next_src = OPCODE_I[4] ? `COD_SEL_STACK : `COD_SEL_DIR;
					next_dst = OPCODE_I[4] ? `COD_SEL_DIR : `COD_SEL_STACK;
					next_len = `COD_LEN_2;
					next_mc = `COD_MC_2;
				end
				default: begin
					// outside these groups: flagged for the other decoders
					next_illegal = 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs, valid the cycle after the opcode is offered while the timer is not busy
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			DEC_VALID_O <= 1'b0;
			DEC_ILLEGAL_O <= 1'b0;
			OP_CLASS_O <= `COD_OP_ILLEGAL;
			SRC_SEL_O <= `COD_SEL_NONE;
			DST_SEL_O <= `COD_SEL_NONE;
			REG_NUM_O <= 3'h0;
			IND_SEL_O <= 1'b0;
			XDAT_WRITE_O <= 1'b0;
			LEN_O <= `COD_LEN_1;
			MC_COUNT_O <= `COD_MC_1;
		end else begin
			DEC_VALID_O <= OPCODE_VALID_I && !tm_busy; // [RULE24]
			if (OPCODE_VALID_I && !tm_busy) begin
				DEC_ILLEGAL_O <= next_illegal;
				OP_CLASS_O <= next_op; // [RULE24]
				SRC_SEL_O <= next_src;
				DST_SEL_O <= next_dst;
				REG_NUM_O <= OPCODE_I[2:0]; // [RULE23]
				IND_SEL_O <= OPCODE_I[0];
				XDAT_WRITE_O <= (next_op == `COD_OP_MOVX) && OPCODE_I[4];
				LEN_O <= next_len; // [RULE2]
				MC_COUNT_O <= next_mc; // [RULE3]
			end
		end
	end

	cod_mc_timer #(
		.CLKS_PER_MC(CLKS_PER_MC)
	) u_timer (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.start_i(OPCODE_VALID_I && !next_illegal),
		.mc_count_i(next_mc),
		.busy_o(tm_busy),
		.mc_tick_o(tm_tick),
		.done_o(tm_done)
	);

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			EXEC_BUSY_O <= 1'b0;
			MC_TICK_O <= 1'b0;
			EXEC_DONE_O <= 1'b0;
		end else begin
			EXEC_BUSY_O <= tm_busy; // [RULE1]
			MC_TICK_O <= tm_tick;
			EXEC_DONE_O <= tm_done;
		end
	end

endmodule // cod_op_decoder

`default_nettype wire

// ==== cod_op_decoder_bench.sv ====
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.vh"

module cod_op_decoder_bench;
	localparam int CPM = 2;
	logic clk, srst, op_vld;
	logic [7:0] op;
	wire dv, dill, ind, xw, busy, tick, done;
	wire [`COD_OP_W-1:0] cls;
	wire [`COD_SEL_W-1:0] src, dst;
	wire [2:0] rn;
	wire [1:0] len;
	wire [`COD_MC_CNT_W-1:0] mc;
	integer miscompares = 0, num_checks = 0, cyc = 0, seed = 32'hc74c750d, i;

	cod_op_decoder #(.CLKS_PER_MC(CPM)) i_dut (.CLK_I(clk), .SRST_I(srst),
		.OPCODE_VALID_I(op_vld), .OPCODE_I(op), .DEC_VALID_O(dv), .DEC_ILLEGAL_O(dill),
		.OP_CLASS_O(cls), .SRC_SEL_O(src), .DST_SEL_O(dst), .REG_NUM_O(rn), .IND_SEL_O(ind),
		.XDAT_WRITE_O(xw), .LEN_O(len), .MC_COUNT_O(mc), .EXEC_BUSY_O(busy),
		.MC_TICK_O(tick), .EXEC_DONE_O(done));
	////////////////////////////////////////////////////////////////////////////////
	// legal, length and cycles of an opcode
	function automatic logic [5:0] ref_dec(input logic [7:0] o);
		logic al;
		al = o[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hC, 4'hE};
		if (o[3] && al) return 6'h29;
		if (o[3:1] == 3'h3 && (al || o[7:4] == 4'hD)) return 6'h29;
		if (o[7:3] == 5'h15) return 6'h32;
		case (o)
			8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95, 8'h05, 8'h15, 8'h54, 8'h55, 8'h52,
			8'h44, 8'h45, 8'h42, 8'h64, 8'h65, 8'h62, 8'hE5, 8'h74, 8'hC5: return 6'h31;
			8'h53, 8'h43, 8'h63, 8'h85, 8'h90: return 6'h3A;
			8'hA3, 8'h93, 8'h83, 8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3: return 6'h2A;
			8'hA4, 8'h84: return 6'h2C;
			8'hC0, 8'hD0: return 6'h32;
			8'h04, 8'h14, 8'h23, 8'h33, 8'h03, 8'h13, 8'hD4, 8'hE4, 8'hF4, 8'hC4: return 6'h29;
			default: return 6'h00;
		endcase
	endfunction

	// operation class, 1F where not checked
	function automatic logic [4:0] ref_cls(input logic [7:0] o);
		case (o)
			8'hA4: return `COD_OP_MUL;
			8'h84: return `COD_OP_DIV;
			8'hA3: return `COD_OP_INC_DP;
			8'h90: return `COD_OP_MOV_DP;
			8'hC0: return `COD_OP_PUSH;
			8'hD0: return `COD_OP_POP;
			8'h23: return `COD_OP_RL;
			8'h33: return `COD_OP_RLC;
			8'h03: return `COD_OP_RR;
			8'h13: return `COD_OP_RRC;
			8'hD6, 8'hD7: return `COD_OP_XCHD;
			8'h93, 8'h83: return `COD_OP_MOVC;
			8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3: return `COD_OP_MOVX;
			default: ;
		endcase
		if (!o[3]) return 5'h1F;
		case (o[7:4])
			4'h0: return `COD_OP_INC;
			4'h1: return `COD_OP_DEC;
			4'h2: return `COD_OP_ADD;
			4'h3: return `COD_OP_ADDC;
			4'h4: return `COD_OP_OR;
			4'h5: return `COD_OP_AND;
			4'h6: return `COD_OP_XOR;
			4'h9: return `COD_OP_SUBB;
			4'hA, 4'hE: return `COD_OP_MOV;
			4'hC: return `COD_OP_XCH;
			default: return 5'h1F;
		endcase
	endfunction

	// source and destination selects, FF where not checked
	function automatic logic [7:0] ref_sel(input logic [7:0] o);
		logic [3:0] f;
		f = o[3] ? `COD_SEL_BANK : (o[2:1] == 2'h3) ? `COD_SEL_IND :
			(o[2:0] == 3'h5) ? `COD_SEL_DIR : `COD_SEL_IMM;
		case (o)
			8'h74: return {`COD_SEL_IMM, `COD_SEL_ACC};
			8'h90: return {`COD_SEL_IMM16, `COD_SEL_DP};
			8'hA3: return {`COD_SEL_DP, `COD_SEL_DP};
			8'hA4, 8'h84: return {`COD_SEL_B, `COD_SEL_ACC};
			8'h85: return {`COD_SEL_DIR, `COD_SEL_DIR};
			8'h52, 8'h42, 8'h62: return {`COD_SEL_ACC, `COD_SEL_DIR};
			8'h53, 8'h43, 8'h63: return {`COD_SEL_IMM, `COD_SEL_DIR};
			8'hC0: return {`COD_SEL_DIR, `COD_SEL_STACK};
			8'hD0: return {`COD_SEL_STACK, `COD_SEL_DIR};
			8'h93: return {`COD_SEL_CODE_DP, `COD_SEL_ACC};
			8'h83: return {`COD_SEL_CODE_PC, `COD_SEL_ACC};
			8'hE0: return {`COD_SEL_XDAT_DP, `COD_SEL_ACC};
			8'hF0: return {`COD_SEL_ACC, `COD_SEL_XDAT_DP};
			8'hE2, 8'hE3: return {`COD_SEL_XDAT_IND, `COD_SEL_ACC};
			8'hF2, 8'hF3: return {`COD_SEL_ACC, `COD_SEL_XDAT_IND};
			8'hD6, 8'hD7: return {`COD_SEL_IND, `COD_SEL_ACC};
			default: ;
		endcase
		if (o[3:0] < 4'h4) return 8'hFF;
		case (o[7:4])
			4'h0, 4'h1: return (o[3:0] == 4'h4) ? {`COD_SEL_ACC, `COD_SEL_ACC} : {f, f};
			4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9: return {f, `COD_SEL_ACC};
			4'hA: return o[3] ? {`COD_SEL_DIR, `COD_SEL_BANK} : 8'hFF;
			4'hC, 4'hE: return (o[3:0] == 4'h4) ? 8'hFF : {f, `COD_SEL_ACC};
			default: return 8'hFF;
		endcase
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic rst;
		srst <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk(len, 1);
		chk(mc, 1);
		chk({dv, busy, tick, done}, 0);
		@(posedge clk);
		srst <= 1'b0;
	endtask

	// offer one opcode, optionally offer its complement for three clocks while busy
	task automatic run(input logic [7:0] o, input bit refuse);
		integer n, ndv, t, lim;
		logic [5:0] e;
		logic [4:0] c;
		logic [7:0] s;
		e = ref_dec(o);
		c = ref_cls(o);
		s = ref_sel(o);
		@(posedge clk);
		op <= o;
		op_vld <= 1'b1;
		@(posedge clk);
		op_vld <= 1'b0;
		op <= ~o;
		#1;
		chk(dv, 1);
		chk(dill, !e[5]);
		if (s !== 8'hFF) chk({src, dst}, s);
		if (e[5]) begin
			chk(len, e[4:3]);
			chk(mc, e[2:0]);
			chk(ind, o[0]);
		end
		if (c !== 5'h1F) chk(cls, c);
		if (e[5] && o[3]) chk(rn, o[2:0]);
		if (c === `COD_OP_MOVX) chk(xw, o[4]);
		lim = e[5] ? 20 : 6;
		n = 0;
		ndv = 0;
		t = 0;
		while (done !== 1'b1 && n < lim) begin
			@(posedge clk);
			if (refuse) op_vld <= (n < 3);
			#1;
			n++;
			ndv += (dv === 1'b1);
			t += (tick === 1'b1);
		end
		// done output lags the timer by one register stage
		chk(n, e[5] ? CPM * e[2:0] + 1 : lim);
		chk(t, e[5] ? e[2:0] : 0);
		chk(ndv, 0);
		if (c !== 5'h1F) chk(cls, c);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			test_done;
		end
	end

	initial begin
		srst = 1'b1;
		op_vld = 1'b0;
		op = 8'h00;
		rst;
		for (i = 0; i < 256; i++) run(i[7:0], 1'b0);
		run(8'hA4, 1'b1);
		run(8'h84, 1'b1);
		run(8'h90, 1'b1);
		@(posedge clk);
		op <= 8'hA4;
		op_vld <= 1'b1;
		@(posedge clk);
		op_vld <= 1'b0;
		repeat (2) @(posedge clk);
		rst;
		run(8'h24, 1'b0);
		repeat (100) run($random(seed), 1'b0);
		test_done;
	end
endmodule // cod_op_decoder_bench

bind cod_op_decoder cod_op_decoder_checker #(.CLKS_PER_MC(CLKS_PER_MC)) i_chk (
	.CLK_I(CLK_I), .SRST_I(SRST_I), .DEC_VALID_O(DEC_VALID_O), .DEC_ILLEGAL_O(DEC_ILLEGAL_O),
	.OP_CLASS_O(OP_CLASS_O), .LEN_O(LEN_O), .MC_COUNT_O(MC_COUNT_O),
	.EXEC_BUSY_O(EXEC_BUSY_O), .MC_TICK_O(MC_TICK_O), .EXEC_DONE_O(EXEC_DONE_O));
`default_nettype wire

// ==== cod_op_decoder_checker.sv ====
// port assertions for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.vh"

module cod_op_decoder_checker #(
	parameter CLKS_PER_MC = `COD_CLKS_PER_MC
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic SRST_I,
	// decode results
	input wire logic DEC_VALID_O,
	input wire logic DEC_ILLEGAL_O,
	input wire logic [`COD_OP_W-1:0] OP_CLASS_O,
	input wire logic [1:0] LEN_O,
	input wire logic [`COD_MC_CNT_W-1:0] MC_COUNT_O,
	// execution timing
	input wire logic EXEC_BUSY_O,
	input wire logic MC_TICK_O,
	input wire logic EXEC_DONE_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	logic go;
	assign go = DEC_VALID_O && !DEC_ILLEGAL_O;
	////////////////////////////////////////////////////////////////////////////////
	a_done_one_mc: assert property (go && MC_COUNT_O == 3'h1 |-> ##1 !EXEC_DONE_O [*2] ##1 EXEC_DONE_O)
		else $error("done late or early for one cycle");
	a_done_two_mc: assert property (go && MC_COUNT_O == 3'h2 |-> ##1 !EXEC_DONE_O [*4] ##1 EXEC_DONE_O)
		else $error("done late or early for two cycles");
	a_done_four_mc: assert property (go && MC_COUNT_O == 3'h4 |-> ##1 !EXEC_DONE_O [*8] ##1 EXEC_DONE_O)
		else $error("done late or early for four cycles");
	a_tick_gap: assert property (MC_TICK_O |=> !MC_TICK_O)
		else $error("ticks closer than two clocks");
	a_done_on_tick: assert property (EXEC_DONE_O |-> MC_TICK_O)
		else $error("done without tick");
	a_len_mc_range: assert property (go |-> LEN_O != 2'h0 && MC_COUNT_O inside {3'h1, 3'h2, 3'h4})
		else $error("length or cycles out of range");
	a_mul_div_four: assert property (DEC_VALID_O && OP_CLASS_O inside {`COD_OP_MUL, `COD_OP_DIV} |-> MC_COUNT_O == 3'h4 && LEN_O == 2'h1)
		else $error("multiply or divide timing");
	a_dp_inc_form: assert property (DEC_VALID_O && OP_CLASS_O == `COD_OP_INC_DP |-> MC_COUNT_O == 3'h2 && LEN_O == 2'h1)
		else $error("pointer increment form");
	a_dp_load_form: assert property (DEC_VALID_O && OP_CLASS_O == `COD_OP_MOV_DP |-> MC_COUNT_O == 3'h2 && LEN_O == 2'h3)
		else $error("pointer load form");
	a_stack_form: assert property (DEC_VALID_O && OP_CLASS_O inside {`COD_OP_PUSH, `COD_OP_POP} |-> MC_COUNT_O == 3'h2 && LEN_O == 2'h2)
		else $error("push or pop form");
	a_fields_hold: assert property (!DEC_VALID_O |-> $stable(OP_CLASS_O) && $stable(LEN_O) && $stable(MC_COUNT_O))
		else $error("fields changed without decode");
	a_illegal_idle: assert property (DEC_VALID_O && DEC_ILLEGAL_O |=> !EXEC_BUSY_O [*3])
		else $error("illegal opcode started timer");
	c_four_mc: cover property (go && MC_COUNT_O == 3'h4);
	c_three_bytes: cover property (go && LEN_O == 2'h3);
	c_illegal: cover property (DEC_VALID_O && DEC_ILLEGAL_O);
	c_done: cover property (EXEC_DONE_O);
endmodule // cod_op_decoder_checker
`default_nettype wire

// ==== cod_regs.vh ====
// constants for the opcode decoder: classes, operand selects, timing
`ifndef COD_REGS_VH
`define COD_REGS_VH

// clock and machine cycle timing
`define COD_CLK_PERIOD_NS 10
`define COD_CLKS_PER_MC 2
`define COD_MC_CNT_W 3

// instruction lengths in bytes
`define COD_LEN_1 2'h1
`define COD_LEN_2 2'h2
`define COD_LEN_3 2'h3

// execution times in machine cycles
`define COD_MC_1 3'h1
`define COD_MC_2 3'h2
`define COD_MC_4 3'h4

// operation classes
`define COD_OP_W 5
`define COD_OP_ILLEGAL 5'h00
`define COD_OP_ADD 5'h01
`define COD_OP_ADDC 5'h02
`define COD_OP_SUBB 5'h03
`define COD_OP_INC 5'h04
`define COD_OP_DEC 5'h05
`define COD_OP_INC_DP 5'h06
`define COD_OP_MUL 5'h07
`define COD_OP_DIV 5'h08
`define COD_OP_DA 5'h09
`define COD_OP_AND 5'h0A
`define COD_OP_OR 5'h0B
`define COD_OP_XOR 5'h0C
`define COD_OP_CLR 5'h0D
`define COD_OP_CPL 5'h0E
`define COD_OP_SWAP 5'h0F
`define COD_OP_RL 5'h10
`define COD_OP_RLC 5'h11
`define COD_OP_RR 5'h12
`define COD_OP_RRC 5'h13
`define COD_OP_MOV 5'h14
`define COD_OP_MOV_DP 5'h15
`define COD_OP_MOVC 5'h16
`define COD_OP_MOVX 5'h17
`define COD_OP_PUSH 5'h18
`define COD_OP_POP 5'h19
`define COD_OP_XCH 5'h1A
`define COD_OP_XCHD 5'h1B

// operand selects
`define COD_SEL_W 4
`define COD_SEL_NONE 4'h0
`define COD_SEL_ACC 4'h1
`define COD_SEL_BANK 4'h2
`define COD_SEL_DIR 4'h3
`define COD_SEL_IND 4'h4
`define COD_SEL_IMM 4'h5
`define COD_SEL_B 4'h6
`define COD_SEL_DP 4'h7
`define COD_SEL_CODE_DP 4'h8
`define COD_SEL_CODE_PC 4'h9
`define COD_SEL_XDAT_DP 4'hA
`define COD_SEL_XDAT_IND 4'hB
`define COD_SEL_STACK 4'hC
`define COD_SEL_IMM16 4'hD

`endif
